// ===== design/pssv_code_select.sv
// module: normal/sleep voltage code selector for one converter
`timescale 1ns/1ps
module pssv_code_select
  import pssv_pkg::*;
(
  input wire logic [6:0] normal_code,
  input wire logic [6:0] sleep_code,
  input wire logic sleep_enable,
  input wire logic pin_select,
  input wire logic first_sleep_input,
  input wire logic second_sleep_input,
  output pssv_sel_t sel
);
  logic pin_level;

  // pin choice is a strap, never a register field
  assign pin_level = (pin_select == PSSV_PIN_SECOND) ? second_sleep_input : first_sleep_input;

  always_comb begin
    sel.in_sleep = sleep_enable && !pin_level;
    sel.code = sel.in_sleep ? sleep_code : normal_code;
  end
endmodule

// ===== design/pssv_pkg.sv
// package: register map, field layout and carriers for the shutdown/sleep/code register slice
package pssv_pkg;
  localparam logic [7:0] PSSV_ADDR_FORCE_SHUTDOWN = 8'h91;
  localparam logic [7:0] PSSV_ADDR_CONV1_SLEEP = 8'h92;
  localparam logic [7:0] PSSV_ADDR_CONV2_SLEEP = 8'h93;
  localparam logic [7:0] PSSV_ADDR_CONV4_VOLTAGE = 8'h94;
  localparam logic [7:0] PSSV_ADDR_CONV4_SLEEP_VOLTAGE = 8'h95;
  localparam int PSSV_CODE_MSB = 7;
  localparam int PSSV_CODE_LSB = 1;
  localparam int PSSV_FLAG_BIT = 0;
  localparam logic [7:0] PSSV_RESET_BYTE = 8'h00;
  localparam logic [6:0] PSSV_RESET_CODE = 7'h00;
  localparam logic [7:0] PSSV_READ_ZERO = 8'h00;
  localparam logic PSSV_PIN_FIRST = 1'b0;
  localparam logic PSSV_PIN_SECOND = 1'b1;
  localparam int PSSV_SHUTDOWN_PULSE_CYCLES = 4;

  typedef enum logic [1:0] {
    PSSV_ST_RUN = 2'b00,
    PSSV_ST_SHUTDOWN = 2'b01,
    PSSV_ST_RELEASE = 2'b10
  } pssv_state_t;

  // one register access request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pssv_req_t;

  // per-converter voltage selection output
  typedef struct packed {
    logic [6:0] code;
    logic in_sleep;
  } pssv_sel_t;
endpackage

// ===== design/pssv_regs.sv
// module: shutdown, converter sleep and converter 4 code register bank
//
// Summary of operation
// - Writing shutdown bit 1 resets device and registers
// - Shutdown bit self-clears, reads back zero
// - Shutdown write gets no acknowledge
// - Converter 1 sleep disabled: always normal code
// - Converter 1 enabled: sleep code while pin low
// - Converter 2: sleep code if enabled, pin low
// - Sleep pin assignment fixed by factory strap
// - Sleep registers: code bits 7:1, enable bit 0
// - Converter 4 register: code 7:1, decay bit 0
// - Decay 0: actively slew down to lower code
// - Decay 1: passive decay to lower code
// - Converter 4 sleep register: code bits 7:1
`timescale 1ns/1ps
module pssv_regs
  import pssv_pkg::*;
#(
  parameter logic CONV1_PIN_SELECT = PSSV_PIN_FIRST,
  parameter logic CONV2_PIN_SELECT = PSSV_PIN_SECOND
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input pssv_req_t req,
  output logic ack,
  output logic [7:0] rdata,
  input wire logic first_sleep_input,
  input wire logic second_sleep_input,
  input wire logic [6:0] conv1_normal_code,
  input wire logic [6:0] conv2_normal_code,
  input wire logic conv4_sleep_active,
  output pssv_sel_t conv1_sel,
  output pssv_sel_t conv2_sel,
  output logic [6:0] conv4_target_code,
  output logic conv4_active_slew,
  output logic conv4_passive_decay,
  output logic emergency_shutdown
);
  ////////////////////////////////////////////////////////////////////////////////
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic srst_n;
  pssv_state_t state_reg;
  logic [2:0] pulse_cnt_reg;
  logic regs_clear;
  logic [7:0] conv1_sleep_control_reg;
  logic [7:0] conv2_sleep_control_reg;
  logic [7:0] conv4_voltage_code_reg;
  logic [7:0] conv4_sleep_voltage_code_reg;
  logic [6:0] conv4_prev_target_reg;
  logic [6:0] conv4_target;
  logic shutdown_hit;
  logic [7:0] rdata_next;

  function automatic logic [6:0] code_of(input logic [7:0] value);
    code_of = value[PSSV_CODE_MSB:PSSV_CODE_LSB];
  endfunction

  function automatic logic hit(input pssv_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign srst_n = rst_sync2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // shutdown sequencer: a write of 1 pulses the emergency shutdown and wipes every register
  assign shutdown_hit = hit(req, PSSV_ADDR_FORCE_SHUTDOWN) && req.wdata[PSSV_FLAG_BIT];

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      state_reg <= PSSV_ST_RUN;
      pulse_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      case (state_reg)
        PSSV_ST_RUN: begin
          if (shutdown_hit) begin
            state_reg <= PSSV_ST_SHUTDOWN;
            pulse_cnt_reg <= 3'h0;
          end
        end
        PSSV_ST_SHUTDOWN: begin
          pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
          if (pulse_cnt_reg == 3'(PSSV_SHUTDOWN_PULSE_CYCLES - 1)) begin
            state_reg <= PSSV_ST_RELEASE;
          end
        end
        PSSV_ST_RELEASE: begin
          state_reg <= PSSV_ST_RUN;
        end
        default: begin
          state_reg <= PSSV_ST_RUN;
        end
      endcase
    end
  end

  assign emergency_shutdown = (state_reg == PSSV_ST_SHUTDOWN);
  assign regs_clear = (state_reg != PSSV_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////////
  // writes are ignored while the shutdown is in progress, since the device is going down
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      conv1_sleep_control_reg <= PSSV_RESET_BYTE;
      conv2_sleep_control_reg <= PSSV_RESET_BYTE;
    end else if (clk_en) begin
      if (regs_clear) begin
        conv1_sleep_control_reg <= PSSV_RESET_BYTE;
        conv2_sleep_control_reg <= PSSV_RESET_BYTE;
      end else begin
        if (hit(req, PSSV_ADDR_CONV1_SLEEP)) begin
          conv1_sleep_control_reg <= req.wdata;
        end
        if (hit(req, PSSV_ADDR_CONV2_SLEEP)) begin
          conv2_sleep_control_reg <= req.wdata;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      conv4_voltage_code_reg <= PSSV_RESET_BYTE;
      conv4_sleep_voltage_code_reg <= PSSV_RESET_BYTE;
    end else if (clk_en) begin
      if (regs_clear) begin
        conv4_voltage_code_reg <= PSSV_RESET_BYTE;
        conv4_sleep_voltage_code_reg <= PSSV_RESET_BYTE;
      end else begin
        if (hit(req, PSSV_ADDR_CONV4_VOLTAGE)) begin
          conv4_voltage_code_reg <= req.wdata;
        end
        if (hit(req, PSSV_ADDR_CONV4_SLEEP_VOLTAGE)) begin
          // bit 0 is reserved and never stored
          conv4_sleep_voltage_code_reg <= {code_of(req.wdata), 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge and read data; the shutdown bit itself is never stored, so it reads zero
  always_comb begin
    case (req.addr)
      PSSV_ADDR_FORCE_SHUTDOWN: rdata_next = PSSV_READ_ZERO;
      PSSV_ADDR_CONV1_SLEEP: rdata_next = conv1_sleep_control_reg;
      PSSV_ADDR_CONV2_SLEEP: rdata_next = conv2_sleep_control_reg;
      PSSV_ADDR_CONV4_VOLTAGE: rdata_next = conv4_voltage_code_reg;
      PSSV_ADDR_CONV4_SLEEP_VOLTAGE: rdata_next = conv4_sleep_voltage_code_reg;
      default: rdata_next = PSSV_READ_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      rdata <= PSSV_READ_ZERO;
    end else if (clk_en && req.rd) begin
      rdata <= rdata_next;
    end
  end

  // the front end withholds its acknowledge for the write that triggers shutdown
  assign ack = (req.wr || req.rd) && !shutdown_hit && !regs_clear;

  ////////////////////////////////////////////////////////////////////////////////
  pssv_code_select u_conv1_select (
    .normal_code(conv1_normal_code),
    .sleep_code(code_of(conv1_sleep_control_reg)),
    .sleep_enable(conv1_sleep_control_reg[PSSV_FLAG_BIT]),
    .pin_select(CONV1_PIN_SELECT),
    .first_sleep_input(first_sleep_input),
    .second_sleep_input(second_sleep_input),
    .sel(conv1_sel)
  );

  pssv_code_select u_conv2_select (
    .normal_code(conv2_normal_code),
    .sleep_code(code_of(conv2_sleep_control_reg)),
    .sleep_enable(conv2_sleep_control_reg[PSSV_FLAG_BIT]),
    .pin_select(CONV2_PIN_SELECT),
    .first_sleep_input(first_sleep_input),
    .second_sleep_input(second_sleep_input),
    .sel(conv2_sel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // converter 4: target follows sleep state; a drop in target picks slew or passive decay
  assign conv4_target = conv4_sleep_active ? code_of(conv4_sleep_voltage_code_reg)
                                           : code_of(conv4_voltage_code_reg);

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      conv4_target_code <= PSSV_RESET_CODE;
      conv4_prev_target_reg <= PSSV_RESET_CODE;
      conv4_active_slew <= 1'b0;
      conv4_passive_decay <= 1'b0;
    end else if (clk_en) begin
      conv4_target_code <= conv4_target;
      conv4_prev_target_reg <= conv4_target;
      if (conv4_target < conv4_prev_target_reg) begin
        conv4_active_slew <= !conv4_voltage_code_reg[PSSV_FLAG_BIT];
        conv4_passive_decay <= conv4_voltage_code_reg[PSSV_FLAG_BIT];
      end else begin
        conv4_active_slew <= 1'b0;
        conv4_passive_decay <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/pssv_chk.sv
// checker: port-level properties of the register slice
`timescale 1ns/1ps
module pssv_chk
  import pssv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input pssv_req_t req,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic first_sleep_input,
  input wire logic second_sleep_input,
  input wire logic [6:0] conv1_normal_code,
  input wire logic [6:0] conv2_normal_code,
  input wire logic conv4_sleep_active,
  input pssv_sel_t conv1_sel,
  input pssv_sel_t conv2_sel,
  input wire logic [6:0] conv4_target_code,
  input wire logic conv4_active_slew,
  input wire logic conv4_passive_decay,
  input wire logic emergency_shutdown
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic sd_wr;
  assign sd_wr = req.wr && req.addr == PSSV_ADDR_FORCE_SHUTDOWN && req.wdata[0];
  ////////////////////////////////////////
  sequence s_pulse;
    emergency_shutdown [*4] ##1 !emergency_shutdown;
  endsequence
  property p_nack; sd_wr |-> !ack; endproperty
  a_nack: assert property (p_nack) else $error("shutdown write acknowledged");
  // a trigger while the pulse or its release cycle runs is refused, so it is left out
  property p_pulse; clk_en && sd_wr && !emergency_shutdown && !$past(emergency_shutdown) |=> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("shutdown pulse wrong");
  property p_clear; $fell(emergency_shutdown) |-> conv4_target_code == PSSV_RESET_CODE; endproperty
  a_clear: assert property (p_clear) else $error("code kept over shutdown");
  property p_c1; first_sleep_input |-> conv1_sel == {conv1_normal_code, 1'b0}; endproperty
  a_c1: assert property (p_c1) else $error("conv1 not normal with pin high");
  property p_c2; second_sleep_input |-> conv2_sel == {conv2_normal_code, 1'b0}; endproperty
  a_c2: assert property (p_c2) else $error("conv2 not normal with pin high");
  // a flag may only follow a real drop of the target, and never both flags at once
  property p_excl;
    $past(clk_en) && (conv4_active_slew || conv4_passive_decay)
      |-> !(conv4_active_slew && conv4_passive_decay) && conv4_target_code < $past(conv4_target_code);
  endproperty
  a_excl: assert property (p_excl) else $error("slew and decay together");
  property p_drop;
    !emergency_shutdown && conv4_target_code < $past(conv4_target_code)
      |-> ##[0:1] (conv4_active_slew || conv4_passive_decay);
  endproperty
  a_drop: assert property (p_drop) else $error("drop without slew or decay");
  property p_rd91; clk_en && req.rd && req.addr == PSSV_ADDR_FORCE_SHUTDOWN |=> rdata == PSSV_READ_ZERO; endproperty
  a_rd91: assert property (p_rd91) else $error("shutdown register not zero");
  property p_rd95; clk_en && req.rd && req.addr == PSSV_ADDR_CONV4_SLEEP_VOLTAGE |=> !rdata[PSSV_FLAG_BIT]; endproperty
  a_rd95: assert property (p_rd95) else $error("reserved bit set");
endmodule
bind pssv_regs pssv_chk chk_u (.core_clk, .rst_n, .clk_en, .req, .ack, .rdata, .first_sleep_input,
  .second_sleep_input, .conv1_normal_code, .conv2_normal_code, .conv4_sleep_active, .conv1_sel, .conv2_sel,
  .conv4_target_code, .conv4_active_slew, .conv4_passive_decay, .emergency_shutdown);

// ===== sim/pssv_host.sv
// host model: single-byte register accesses
`timescale 1ns/1ps
module pssv_host
  import pssv_pkg::*;
(
  input wire logic core_clk,
  input wire logic ack,
  input wire logic [7:0] rdata,
  output pssv_req_t req
);
  initial req = '0;
  // a missing acknowledge is returned as is, no retry, since a shutdown write never gets one
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic k,
    output logic [7:0] q);
    @(posedge core_clk);
    #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
    #1 k = ack;
    @(posedge core_clk);
    // released lines show the inverse so stale values are never mistaken for live ones
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = rdata;
  endtask
endmodule

// ===== sim/testbench.sv
// testbench: register slice scenarios driven through the host model
`timescale 1ns/1ps
module testbench;
  import pssv_pkg::*;
  logic core_clk = 0;
  logic rst_n = 0;
  logic s1 = 1;
  logic s2 = 1;
  logic c4s = 0;
  logic ce = 1;
  logic k;
  logic sl;
  logic dc;
  logic es;
  logic ack;
  logic [7:0] q;
  logic [7:0] rdata;
  logic [6:0] c4t;
  pssv_req_t req;
  pssv_sel_t c1;
  pssv_sel_t c2;
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 core_clk = ~core_clk;
  pssv_host host_u (.core_clk, .ack, .rdata, .req);
  pssv_regs dut_u (.core_clk, .rst_n, .clk_en(ce), .req, .ack, .rdata, .first_sleep_input(s1),
    .second_sleep_input(s2), .conv1_normal_code(7'h11), .conv2_normal_code(7'h22), .conv4_sleep_active(c4s),
    .conv1_sel(c1), .conv2_sel(c2), .conv4_target_code(c4t), .conv4_active_slew(sl),
    .conv4_passive_decay(dc), .emergency_shutdown(es));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ek);
    host_u.acc(1'b1, a, d, k, q);
    chk({7'h00, k}, {7'h00, ek});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_u.acc(1'b0, a, 8'h00, k, q);
    chk(q, e);
  endtask
  task automatic pins(input logic a, input logic b, input logic [7:0] e1, input logic [7:0] e2);
    @(posedge core_clk);
    #1 s1 = a;
    s2 = b;
    #1 chk(c1, e1);
    chk(c2, e2);
  endtask
  task automatic watch(input logic [1:0] e);
    logic [1:0] s = 2'h0;
    repeat (3) begin
      s |= {sl, dc};
      @(posedge core_clk);
      #1;
    end
    chk({6'h00, s}, {6'h00, e});
  endtask
  task automatic t_map;
    for (int i = 0; i < 5; i++) rd(8'(8'h91 + i), 8'h00);
    for (int i = 1; i < 5; i++) wr(8'(8'h91 + i), 8'hFF, 1'b1);
    for (int i = 1; i < 5; i++) rd(8'(8'h91 + i), (i == 4) ? 8'hFE : 8'hFF);
    wr(8'h90, 8'hFF, 1'b1);
    rd(8'h90, 8'h00);
    rd(PSSV_ADDR_FORCE_SHUTDOWN, 8'h00);
  endtask
  task automatic t_sleep;
    wr(PSSV_ADDR_CONV1_SLEEP, 8'h55, 1'b1);
    wr(PSSV_ADDR_CONV2_SLEEP, 8'h67, 1'b1);
    pins(1'b0, 1'b1, 8'h55, 8'h44);
    pins(1'b1, 1'b0, 8'h22, 8'h67);
    wr(PSSV_ADDR_CONV1_SLEEP, 8'h54, 1'b1);
    wr(PSSV_ADDR_CONV2_SLEEP, 8'h66, 1'b1);
    pins(1'b0, 1'b0, 8'h22, 8'h44);
    pins(1'b1, 1'b1, 8'h22, 8'h44);
  endtask
  task automatic t_decay;
    wr(PSSV_ADDR_CONV4_VOLTAGE, 8'h80, 1'b1);
    wr(PSSV_ADDR_CONV4_VOLTAGE, 8'h20, 1'b1);
    watch(2'b10);
    chk({1'b0, c4t}, 8'h10);
    wr(PSSV_ADDR_CONV4_VOLTAGE, 8'h81, 1'b1);
    wr(PSSV_ADDR_CONV4_VOLTAGE, 8'h21, 1'b1);
    watch(2'b01);
    wr(PSSV_ADDR_CONV4_SLEEP_VOLTAGE, 8'h0B, 1'b1);
    c4s = 1;
    repeat (3) @(posedge core_clk);
    #1 chk({1'b0, c4t}, 8'h05);
    c4s = 0;
  endtask
  // a write taken while the enable is low must leave the register as it was
  task automatic t_freeze;
    @(posedge core_clk);
    #1 ce = 0;
    wr(PSSV_ADDR_CONV1_SLEEP, 8'hAA, 1'b1);
    @(posedge core_clk);
    #1 ce = 1;
    rd(PSSV_ADDR_CONV1_SLEEP, 8'h54);
  endtask
  task automatic t_sd;
    wr(PSSV_ADDR_FORCE_SHUTDOWN, 8'hFE, 1'b1);
    chk({7'h00, es}, 8'h00);
    rd(PSSV_ADDR_CONV1_SLEEP, 8'h54);
    wr(PSSV_ADDR_FORCE_SHUTDOWN, 8'h01, 1'b0);
    chk({7'h00, es}, 8'h01);
    wr(PSSV_ADDR_CONV1_SLEEP, 8'h0B, 1'b0);
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < 5; i++) rd(8'(8'h91 + i), 8'h00);
    chk({1'b0, c4t}, 8'h00);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1;
    repeat (3) @(posedge core_clk);
    t_map;
    t_sleep;
    t_decay;
    t_freeze;
    t_sd;
    give_verdict;
  end
  // the whole run needs well under 300 cycles
  initial begin
    #20000;
    n_mismatch++;
    give_verdict;
  end
endmodule
